/* File: fltlog_defines.svh */
// Constants of the fault buffer and history logger: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the logger module.
`ifndef FLTLOG_DEFINES_SVH
`define FLTLOG_DEFINES_SVH
// Register byte offsets on the AXI4-Lite port
`define FL_STATUS_OFS   12'h000
`define FL_CONTROL_OFS  12'h004
`define FL_COUNTER_OFS  12'h008
`define FL_OLDEST_OFS   12'h00C
`define FL_RT_DAYS_OFS  12'h010
`define FL_RT_MS_OFS    12'h014
`define FL_FILL_OFS     12'h018
// Record window: bit 11 set, index in [10:5], field in [4:2]
`define FL_REC_SEL_BIT  11
`define FL_F_CODE       3'h0
`define FL_F_FIXED      3'h1
`define FL_F_FLOAT      3'h2
`define FL_F_ARR_DAYS   3'h3
`define FL_F_ARR_MS     3'h4
`define FL_F_REM_DAYS   3'h5
`define FL_F_REM_MS     3'h6
`define FL_F_FLAGS      3'h7
// Field positions
`define FL_STAT_FAULT_BIT 3
`define FL_CTRL_ACK_BIT   7
// Buffer and history geometry
`define FL_BUF_DEPTH      8
`define FL_HIST_FIRST     8
`define FL_HIST_LAST      63
`define FL_OVERWRITE_SLOT 3'h6
// Reset values
`define FL_CTRL_RESET     32'h0000_0000
`define FL_COUNT_RESET    32'h0000_0000
// Timing: one millisecond at the clock period, day length in ms
`define FL_MS_NS          1000000
`define FL_CLK_NS         10
`define FL_MS_PER_DAY     86400000
// AXI responses
`define FL_RESP_OKAY      2'h0
`define FL_RESP_SLVERR    2'h2
`endif

/* File: fltlog_pkg.sv */
// Types shared by the fault logger: one stored fault record.
// Assumes the defines header is on the include path.
`include "fltlog_defines.svh"
package fltlog_pkg;
    typedef struct packed {
        logic        vld;
        logic        intl;
        logic [31:0] code;
        logic [31:0] fix;
        logic [31:0] flt;
        logic [15:0] ad;
        logic [31:0] ams;
        logic [15:0] rd;
        logic [31:0] rms;
    } fltlog_rec_t;
endpackage

/* File: fltlog_logger.sv */
// Fault buffer, fault history, runtime clock and AXI4-Lite register port.
// Assumes fault sources and ack inputs synchronous to aclk, one clock.
`timescale 1ns/1ns
`include "fltlog_defines.svh"
module fltlog_logger #(
    parameter int CYC_PER_MS = `FL_MS_NS / `FL_CLK_NS,
    parameter int MS_PER_DAY = `FL_MS_PER_DAY
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    input  wire logic        fault_valid,
    input  wire logic [31:0] fault_code,
    input  wire logic [31:0] fault_value_fixed,
    input  wire logic [31:0] fault_value_float,
    input  wire logic        fault_internal,
    input  wire logic [7:0]  cause_cleared,
    input  wire logic        ack_panel,
    input  wire logic        ack_din2,
    input  wire logic        ack_power_on,
    output logic             ready_led_red
);
    // Refuse parameters the counters cannot serve
    if (CYC_PER_MS < 1 || MS_PER_DAY < 2) begin : g_chk
        $error("fltlog_logger: bad timing parameters");
    end

    fltlog_pkg::fltlog_rec_t buf_q  [0:`FL_BUF_DEPTH-1];
    fltlog_pkg::fltlog_rec_t hist_q [`FL_HIST_FIRST:`FL_HIST_LAST];
    fltlog_pkg::fltlog_rec_t nb     [0:`FL_BUF_DEPTH-1];
    logic [3:0]  cnt_q;
    logic [3:0]  next_cnt;
    logic [31:0] cyc_q;
    logic [31:0] rt_ms;
    logic [15:0] rt_days;
    logic [31:0] control_word_one;
    logic [31:0] fault_case_counter;
    logic        case_open;
    logic        ack_sw;
    logic        clr_all;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write;
    logic [31:0] old_word;
    logic [31:0] merged;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        ack_req;
    logic [7:0]  removable;
    logic        eff;
    logic        any_fault;
    logic [7:0]  intl_vec;

    // Runtime clock: ms from a cycle divider, day count on wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_q   <= 32'h0000_0000;
            rt_ms   <= 32'h0000_0000;
            rt_days <= 16'h0000;
        end else if (cyc_q == 32'(CYC_PER_MS - 1)) begin
            cyc_q <= 32'h0000_0000;
            if (rt_ms == 32'(MS_PER_DAY - 1)) begin
                rt_ms   <= 32'h0000_0000;
                rt_days <= rt_days + 16'h0001;
            end else begin
                rt_ms <= rt_ms + 32'h0000_0001;
            end
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
        end
    end

    // Ack sources; internal faults only yield to power-on
    assign ack_req = ack_panel | ack_din2 | ack_sw | ack_power_on;
    for (genvar i = 0; i < `FL_BUF_DEPTH; i++) begin : g_rm
        assign removable[i] = buf_q[i].vld & cause_cleared[i]
                            & (~buf_q[i].intl | ack_power_on);
        // Internal entries, watched by the power-cycle check
        assign intl_vec[i] = buf_q[i].vld & buf_q[i].intl;
    end
    assign eff = ack_req & (|removable);
    assign any_fault = (cnt_q != 4'h0);

    // Next buffer: pack survivors in order, then place the new fault
    always_comb begin
        int k;
        logic [2:0] slot;
        k = 0;
        slot = 3'h0;
        for (int j = 0; j < `FL_BUF_DEPTH; j++) begin
            nb[j] = '0;
        end
        for (int i = 0; i < `FL_BUF_DEPTH; i++) begin
            if (buf_q[i].vld && !(eff && removable[i])) begin
                nb[k[2:0]] = buf_q[i];
                k = k + 1;
            end
        end
        if (fault_valid) begin
            // Full buffer keeps the last slot, loses slot six
            slot = (k == `FL_BUF_DEPTH) ? `FL_OVERWRITE_SLOT : k[2:0];
            nb[slot].vld  = 1'b1;
            nb[slot].intl = fault_internal;
            nb[slot].code = fault_code;
            nb[slot].fix  = fault_value_fixed;
            nb[slot].flt  = fault_value_float;
            nb[slot].ad   = rt_days;
            nb[slot].ams  = rt_ms;
            nb[slot].rd   = 16'h0000;
            nb[slot].rms  = 32'h0000_0000;
            if (k < `FL_BUF_DEPTH) begin
                k = k + 1;
            end
        end
        next_cnt = k[3:0];
    end

    // Active buffer update; erase wins over everything else
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_all) begin
            cnt_q <= 4'h0;
            for (int i = 0; i < `FL_BUF_DEPTH; i++) begin
                buf_q[i] <= '0;
            end
        end else begin
            cnt_q <= next_cnt;
            for (int i = 0; i < `FL_BUF_DEPTH; i++) begin
                buf_q[i] <= nb[i];
            end
        end
    end

    // History: 56 slots, copy of buffer lands in 8..15, older move up
    for (genvar j = `FL_HIST_FIRST; j <= `FL_HIST_LAST; j++) begin : g_hist
        always_ff @(posedge aclk) begin
            if (!aresetn || clr_all) begin
                hist_q[j] <= '0;
            end else if (eff) begin
                if (j < `FL_HIST_FIRST + `FL_BUF_DEPTH) begin
                    // Empty buffer slots copy as empty records
                    hist_q[j] <= buf_q[j-8];
                    if (removable[j-8]) begin
                        hist_q[j].rd  <= rt_days;
                        hist_q[j].rms <= rt_ms;
                    end
                end else begin
                    hist_q[j] <= hist_q[j-8];
                end
            end
        end
    end

    // Fault cases: an ack that removes an entry closes the case, the next fault opens one
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_all) begin
            fault_case_counter <= `FL_COUNT_RESET;
            case_open          <= 1'b0;
        end else if (fault_valid && (!case_open || eff)) begin
            fault_case_counter <= fault_case_counter + 32'h0000_0001;
            case_open          <= 1'b1;
        end else if (eff) begin
            case_open <= 1'b0;
        end
    end

    // Indicator follows the buffer one cycle late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_led_red <= 1'b0;
        end else begin
            ready_led_red <= any_fault;
        end
    end

    // Write channels: address and data held until both present
    assign do_write = !s_awready && !s_wready && !s_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `FL_RESP_OKAY;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_awready && s_awvalid) begin
                s_awready <= 1'b0;
                aw_addr_q <= s_awaddr;
            end
            if (s_wready && s_wvalid) begin
                s_wready <= 1'b0;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp  <= (aw_addr_q == `FL_CONTROL_OFS || aw_addr_q == `FL_COUNTER_OFS)
                            ? `FL_RESP_OKAY : `FL_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // Byte-lane merge of the pending write
    always_comb begin
        old_word = (aw_addr_q == `FL_CONTROL_OFS) ? control_word_one : fault_case_counter;
        for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] : old_word[b*8 +: 8];
        end
    end

    // Write effects; nonzero counter writes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_word_one <= `FL_CTRL_RESET;
            ack_sw           <= 1'b0;
            clr_all          <= 1'b0;
        end else begin
            ack_sw  <= do_write && aw_addr_q == `FL_CONTROL_OFS
                       && merged[`FL_CTRL_ACK_BIT];
            clr_all <= do_write && aw_addr_q == `FL_COUNTER_OFS
                       && merged == 32'h0000_0000;
            if (do_write && aw_addr_q == `FL_CONTROL_OFS) begin
                control_word_one <= merged;
            end
        end
    end

    // Read decode: record window first, then plain registers
    always_comb begin
        fltlog_pkg::fltlog_rec_t r;
        logic [5:0] ridx;
        r      = '0;
        ridx   = s_araddr[10:5];
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (s_araddr[`FL_REC_SEL_BIT]) begin
            if (s_araddr[1:0] != 2'h0) begin
                rd_err = 1'b1;
            end else begin
                r = (ridx < 6'(`FL_HIST_FIRST)) ? buf_q[ridx[2:0]] : hist_q[ridx];
                case (s_araddr[4:2])
                    `FL_F_CODE:     rd_data = r.code; // fault_code_log
                    `FL_F_FIXED:    rd_data = r.fix;
                    `FL_F_FLOAT:    rd_data = r.flt;
                    `FL_F_ARR_DAYS: rd_data = {16'h0000, r.ad};
                    `FL_F_ARR_MS:   rd_data = r.ams;
                    `FL_F_REM_DAYS: rd_data = {16'h0000, r.rd};
                    `FL_F_REM_MS:   rd_data = r.rms;
                    default:        rd_data = {30'h0000_0000, r.intl, r.vld};
                endcase
            end
        end else if (s_araddr == `FL_STATUS_OFS) begin
            rd_data[`FL_STAT_FAULT_BIT] = ready_led_red;
        end else if (s_araddr == `FL_CONTROL_OFS) begin
            rd_data = control_word_one;
        end else if (s_araddr == `FL_COUNTER_OFS) begin
            rd_data = fault_case_counter;
        end else if (s_araddr == `FL_OLDEST_OFS) begin
            rd_data = buf_q[0].code;
        end else if (s_araddr == `FL_RT_DAYS_OFS) begin
            rd_data = {16'h0000, rt_days};
        end else if (s_araddr == `FL_RT_MS_OFS) begin
            rd_data = rt_ms;
        end else if (s_araddr == `FL_FILL_OFS) begin
            rd_data = {28'h000_0000, cnt_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read channel: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `FL_RESP_OKAY;
        end else if (s_arready && s_arvalid) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_data;
            s_rresp   <= rd_err ? `FL_RESP_SLVERR : `FL_RESP_OKAY;
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // Checks on the recording and acknowledgement paths
    chk_arrival_code: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_valid && !clr_all && !eff && cnt_q < 4'h8
        |=> buf_q[$past(cnt_q[2:0])].code == $past(fault_code))
        else $error("new fault code not stored in next slot");
    chk_value_forms: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_valid && !clr_all && !eff && cnt_q < 4'h8
        |=> buf_q[$past(cnt_q[2:0])].fix == $past(fault_value_fixed)
            && buf_q[$past(cnt_q[2:0])].flt == $past(fault_value_float))
        else $error("fault value forms not stored");
    chk_arrival_time: assert property (@(posedge aclk) disable iff (!aresetn)
        fault_valid && !clr_all && !eff && cnt_q < 4'h8
        |=> buf_q[$past(cnt_q[2:0])].ams == $past(rt_ms)
            && buf_q[$past(cnt_q[2:0])].ad == $past(rt_days)
            && buf_q[$past(cnt_q[2:0])].rms == 32'h0000_0000)
        else $error("arrival time wrong or removal not empty");
    chk_full_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_q == 4'h8 && fault_valid && !eff && !clr_all
        |=> cnt_q == 4'h8 && $stable(buf_q[7]) && buf_q[6].code == $past(fault_code))
        else $error("full buffer overwrite wrong");
    chk_led_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        any_fault |=> ready_led_red)
        else $error("red indicator not raised");
    chk_ack_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_req && removable == 8'h00 && !fault_valid && !clr_all
        |=> $stable(cnt_q) && $stable(hist_q[8]))
        else $error("ack acted with no cleared cause");
    chk_hist_shift: assert property (@(posedge aclk) disable iff (!aresetn)
        eff && !clr_all |=> hist_q[16] == $past(hist_q[8]) && hist_q[63] == $past(hist_q[55]))
        else $error("history not shifted by eight");
    chk_hist_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        eff && !clr_all |=> hist_q[8].code == $past(buf_q[0].code)
            && hist_q[15].vld == $past(buf_q[7].vld))
        else $error("buffer not copied into history");
    chk_removal_stamp: assert property (@(posedge aclk) disable iff (!aresetn)
        eff && removable[0] && !clr_all
        |=> hist_q[8].rd == $past(rt_days) && hist_q[8].rms == $past(rt_ms))
        else $error("removal time not stamped on ack");
    chk_erase_all: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_all |=> cnt_q == 4'h0 && !hist_q[8].vld && fault_case_counter == 32'h0000_0000)
        else $error("zero counter write did not erase");
    chk_internal_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !ack_power_on && !clr_all && !(cnt_q == 4'h8 && fault_valid)
        |=> $countones(intl_vec) >= $past($countones(intl_vec)))
        else $error("internal fault removed without power cycle");
endmodule

/* File: fltlog_src_model.sv */
// Model of the fault sources and acknowledge inputs facing the logger.
// Assumes the bench calls its tasks from one process; all edges are aclk.
`timescale 1ns/1ns
module fltlog_src_model (
    input  wire logic aclk,
    output logic        fault_valid,
    output logic [31:0] fault_code,
    output logic [31:0] fault_value_fixed,
    output logic [31:0] fault_value_float,
    output logic        fault_internal,
    output logic [7:0]  cause_cleared,
    output logic        ack_panel,
    output logic        ack_din2,
    output logic        ack_power_on
);
    // Quiet start: no fault, no request, no cause removed
    initial begin
        fault_valid = 1'b0;
        fault_code = 32'h0000_0000;
        fault_value_fixed = 32'h0000_0000;
        fault_value_float = 32'h0000_0000;
        fault_internal = 1'b0;
        cause_cleared = 8'h00;
        ack_panel = 1'b0;
        ack_din2 = 1'b0;
        ack_power_on = 1'b0;
    end

    // One fault per call; payload inverted after the strobe so stale data never matches
    task automatic raise(input logic [31:0] code, fix, flt, input logic intl);
        @(posedge aclk);
        fault_valid <= 1'b1;
        fault_code <= code;
        fault_value_fixed <= fix;
        fault_value_float <= flt;
        fault_internal <= intl;
        @(posedge aclk);
        fault_valid <= 1'b0;
        fault_code <= ~code;
        fault_value_fixed <= ~fix;
        fault_value_float <= ~flt;
        fault_internal <= ~intl;
    endtask

    // One-cycle request: 0 panel button, 1 digital input, 2 power cycle
    task automatic ack(input int kind);
        @(posedge aclk);
        ack_panel <= (kind == 0);
        ack_din2 <= (kind == 1);
        ack_power_on <= (kind == 2);
        @(posedge aclk);
        ack_panel <= 1'b0;
        ack_din2 <= 1'b0;
        ack_power_on <= 1'b0;
    endtask

    // Removed causes, per current buffer slot; caller re-maps after compaction
    task automatic set_cleared(input logic [7:0] m);
        @(posedge aclk);
        cause_cleared <= m;
    endtask
endmodule

/* File: fltlog_logger_tb.sv */
// Bench of the fault logger: AXI4-Lite tasks, fault traffic, expected values.
// Assumes the logger, its defines header and the source model beside it.
`timescale 1ns/1ns
`include "fltlog_defines.svh"
module fltlog_logger_tb;
    localparam int MSD = 5;
    localparam int LIMIT = 5000;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_awaddr = 12'h000;
    logic [11:0] s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic        s_awvalid = 1'b0;
    logic        s_wvalid = 1'b0;
    logic        s_bready = 1'b0;
    logic        s_arvalid = 1'b0;
    logic        s_rready = 1'b0;
    logic [3:0]  s_wstrb = 4'hF;
    wire logic   s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ready_led_red;
    wire logic [1:0]  s_bresp, s_rresp;
    wire logic [31:0] s_rdata, fault_code, fault_value_fixed, fault_value_float;
    wire logic   fault_valid, fault_internal, ack_panel, ack_din2, ack_power_on;
    wire logic [7:0]  cause_cleared;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          c0;
    logic [31:0] d0, m0, d1, m1;
    logic [1:0]  r;

    fltlog_logger #(.CYC_PER_MS(2), .MS_PER_DAY(MSD)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .fault_valid(fault_valid), .fault_code(fault_code),
        .fault_value_fixed(fault_value_fixed), .fault_value_float(fault_value_float),
        .fault_internal(fault_internal), .cause_cleared(cause_cleared),
        .ack_panel(ack_panel), .ack_din2(ack_din2), .ack_power_on(ack_power_on),
        .ready_led_red(ready_led_red));

    fltlog_src_model u_src (
        .aclk(aclk), .fault_valid(fault_valid), .fault_code(fault_code),
        .fault_value_fixed(fault_value_fixed), .fault_value_float(fault_value_float),
        .fault_internal(fault_internal), .cause_cleared(cause_cleared),
        .ack_panel(ack_panel), .ack_din2(ack_din2), .ack_power_on(ack_power_on));

    // Clock and cycle count; the count cuts a hang short
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
        end
    endtask

    // Write: both channels offered together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rr);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rr = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rr);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic wrchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] rr;
        axw(a, d, rr);
        chk_resp(rr, e);
    endtask
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  rr;
        axr(a, v, rr);
        chk_resp(rr, `FL_RESP_OKAY);
        chk(v & m, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        rdm(a, 32'hFFFF_FFFF, e);
    endtask
    function automatic logic [11:0] rec(input logic [5:0] idx, input logic [2:0] f);
        return {1'b1, idx, f, 2'b00};
    endfunction

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // Empty after reset; unmapped and read-only places refused
        rdchk(`FL_STATUS_OFS, 32'h0000_0000);
        rdchk(`FL_FILL_OFS, 32'h0000_0000);
        axr(12'h01C, d0, r);
        chk_resp(r, `FL_RESP_SLVERR);
        wrchk(`FL_STATUS_OFS, 32'h0000_0008, `FL_RESP_SLVERR);
        // Two faults in one case, each in its own slot
        u_src.raise(32'h0000_0011, 32'h0000_0101, 32'h3F80_0000, 1'b0);
        u_src.raise(32'h0000_0022, 32'h0000_0202, 32'h4000_0000, 1'b0);
        rdchk(rec(6'd0, `FL_F_CODE), 32'h0000_0011);
        rdchk(rec(6'd0, `FL_F_FIXED), 32'h0000_0101);
        rdchk(rec(6'd0, `FL_F_FLOAT), 32'h3F80_0000);
        rdchk(rec(6'd0, `FL_F_REM_DAYS), 32'h0000_0000);
        rdchk(rec(6'd0, `FL_F_REM_MS), 32'h0000_0000);
        axr(rec(6'd1, `FL_F_ARR_MS), d0, r);
        chk({31'h0, d0 < MSD}, 32'h0000_0001);
        rdchk(rec(6'd1, `FL_F_CODE), 32'h0000_0022);
        rdchk(`FL_OLDEST_OFS, 32'h0000_0011);
        rdchk(`FL_COUNTER_OFS, 32'h0000_0001);
        rdm(`FL_STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
        chk({31'h0, ready_led_red}, 32'h0000_0001);
        // Ack with no cause removed has no effect
        u_src.ack(0);
        rdchk(`FL_FILL_OFS, 32'h0000_0002);
        // Control-word ack removes slot 0 and copies both into history
        u_src.set_cleared(8'h01);
        wrchk(`FL_CONTROL_OFS, 32'h0000_0080, `FL_RESP_OKAY);
        u_src.set_cleared(8'h00);
        rdchk(`FL_FILL_OFS, 32'h0000_0001);
        rdchk(rec(6'd0, `FL_F_CODE), 32'h0000_0022);
        rdchk(rec(6'd0, `FL_F_REM_MS), 32'h0000_0000);
        rdchk(rec(6'd8, `FL_F_CODE), 32'h0000_0011);
        rdchk(rec(6'd9, `FL_F_CODE), 32'h0000_0022);
        rdchk(rec(6'd10, `FL_F_FLAGS), 32'h0000_0000);
        rdchk(`FL_OLDEST_OFS, 32'h0000_0022);
        // Internal fault refuses every ack but power cycling
        u_src.raise(32'h0000_0033, 32'h0000_0303, 32'h4040_0000, 1'b1);
        rdchk(`FL_COUNTER_OFS, 32'h0000_0002);
        u_src.set_cleared(8'h02);
        u_src.ack(1);
        u_src.ack(0);
        wrchk(`FL_CONTROL_OFS, 32'h0000_0080, `FL_RESP_OKAY);
        rdchk(`FL_FILL_OFS, 32'h0000_0002);
        u_src.ack(2);
        u_src.set_cleared(8'h00);
        wrchk(`FL_CONTROL_OFS, 32'h0000_0000, `FL_RESP_OKAY);
        // Only lane 1 is strobed, so the ack bit in lane 0 stays clear
        s_wstrb <= 4'h2;
        wrchk(`FL_CONTROL_OFS, 32'h1234_56FF, `FL_RESP_OKAY);
        s_wstrb <= 4'hF;
        rdchk(`FL_CONTROL_OFS, 32'h0000_5600);
        rdchk(`FL_FILL_OFS, 32'h0000_0001);
        rdchk(rec(6'd16, `FL_F_CODE), 32'h0000_0011);
        rdchk(rec(6'd8, `FL_F_CODE), 32'h0000_0022);
        rdchk(rec(6'd9, `FL_F_FLAGS), 32'h0000_0003);
        // Fill to eight, then one more lands in slot 6
        for (int i = 0; i < 8; i++) begin
            u_src.raise(32'h0000_0040 + i, 32'h0000_0000, 32'h0000_0000, 1'b0);
        end
        rdchk(`FL_FILL_OFS, 32'h0000_0008);
        rdchk(rec(6'd6, `FL_F_CODE), 32'h0000_0047);
        rdchk(rec(6'd7, `FL_F_CODE), 32'h0000_0046);
        rdchk(rec(6'd5, `FL_F_CODE), 32'h0000_0044);
        // Nonzero counter write ignored, zero erases buffer, history and counter
        wrchk(`FL_COUNTER_OFS, 32'h0000_0005, `FL_RESP_OKAY);
        rdchk(`FL_COUNTER_OFS, 32'h0000_0003);
        wrchk(`FL_COUNTER_OFS, 32'h0000_0000, `FL_RESP_OKAY);
        rdchk(`FL_FILL_OFS, 32'h0000_0000);
        rdchk(rec(6'd16, `FL_F_FLAGS), 32'h0000_0000);
        rdchk(`FL_COUNTER_OFS, 32'h0000_0000);
        rdm(`FL_STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
        chk({31'h0, ready_led_red}, 32'h0000_0000);
        // Runtime: 20 cycles are exactly two short days
        @(posedge aclk);
        c0 = cyc;
        axr(`FL_RT_DAYS_OFS, d0, r);
        axr(`FL_RT_MS_OFS, m0, r);
        while (cyc != c0 + 20) @(posedge aclk);
        axr(`FL_RT_DAYS_OFS, d1, r);
        axr(`FL_RT_MS_OFS, m1, r);
        chk(d1, d0 + 32'd2);
        chk(m1, m0);
        print_verdict();
    end
endmodule
